// ---- verilog/fdch_proto.v ----
/*
 Host command protocol of a floppy disk controller: status and data
 register pair, command, execution and result phases, interrupt and DMA
 handshakes, terminal count, drive ready polling, read data flow.
 Assumes the host strobes and pins are asynchronous and the drive-side
 data path is a byte stream with sector and id match strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdch_defines.vh"
module fdch_proto #(
   parameter integer TICK_DIV = `FDCH_TICK_CYC
) (
   input wire core_clk,
   input wire rst,
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   input wire register_select_line,
   input wire [7:0] db_in,
   output reg [7:0] db_out,
   output reg db_oe,
   output reg int_q,
   output reg dma_request_output,
   input wire dma_acknowledge_input,
   input wire transfer_end_input,
   input wire [3:0] drive_ready,
   output reg [1:0] drive_select_outputs,
   output reg head_select,
   output reg head_load,
   output reg encoding_density_select,
   output reg [7:0] cylinder_q,
   output reg [3:0] step_interval_q,
   output reg [7:0] short_sector_length_q,
   output reg [7:0] scan_stride_q,
   input wire [7:0] disk_byte,
   input wire disk_byte_vld,
   input wire disk_id_vld,
   input wire [7:0] disk_id_sector,
   input wire disk_sector_end,
   output reg [7:0] host_wr_byte,
   output reg host_wr_vld
);
   localparam [4:0] S_IDLE = 5'h01, S_CMD = 5'h02, S_HEAD = 5'h04, S_EXEC = 5'h08,
      S_RES = 5'h10;
   // Input synchronisers
   reg [3:0] s1_q, s2_q, s3_q;
   reg [3:0] rdy1_q, rdy2_q, rdy3_q;
   reg [7:0] db1_q, db2_q;
   reg a1_q, a2_q, te1_q, te2_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 4'hf;
         s2_q <= 4'hf;
         s3_q <= 4'hf;
         rdy1_q <= 4'h0;
         rdy2_q <= 4'h0;
         rdy3_q <= 4'h0;
         db1_q <= 8'h00;
         db2_q <= 8'h00;
         a1_q <= 1'b0;
         a2_q <= 1'b0;
         te1_q <= 1'b0;
         te2_q <= 1'b0;
      end else begin
         s1_q <= {cs_n, rd_n, wr_n, dma_acknowledge_input};
         s2_q <= s1_q;
         s3_q <= s2_q;
         rdy1_q <= drive_ready;
         rdy2_q <= rdy1_q;
         rdy3_q <= rdy2_q;
         db1_q <= db_in;
         db2_q <= db1_q;
         a1_q <= register_select_line;
         a2_q <= a1_q;
         te1_q <= transfer_end_input;
         te2_q <= te1_q;
      end
   end
   wire dma_acknowledge_input_n = s2_q[0];
   wire sel = !s2_q[3] || !dma_acknowledge_input_n;
   wire rd_act = sel && !s2_q[2];
   wire wr_act = sel && !s2_q[1];
   wire rd_fall = rd_act && (s3_q[2] || (s3_q[3] && s3_q[0]));
   wire wr_fall = wr_act && (s3_q[1] || (s3_q[3] && s3_q[0]));
   wire data_sel = a2_q || !dma_acknowledge_input_n;
   wire tc = te2_q;

   // Command length for a given opcode
   function [3:0] cmd_len;
      input [4:0] op;
      begin
         case (op)
            `FDCH_OP_RDDATA, `FDCH_OP_WRDATA, `FDCH_OP_SCANEQ: cmd_len = `FDCH_LEN_RW;
            `FDCH_OP_SPECIFY, `FDCH_OP_SEEK: cmd_len = `FDCH_LEN_SPEC;
            `FDCH_OP_RECAL: cmd_len = `FDCH_LEN_RECAL;
            default: cmd_len = `FDCH_LEN_ONE;
         endcase
      end
   endfunction

   reg [4:0] st_q;
   reg [3:0] cnt_q, len_q;
   reg [2:0] rcnt_q, rlen_q;
   reg [7:0] cmd_q [0:8];
   reg [7:0] res_q [0:6];
   reg [7:0] hlt_q, hut_q;
   reg nodma_q, spec_q, tc_seen_q, rdy_int_q, dir_q, rqm_q;
   reg [7:0] rec_q, st0_q;
   reg [7:0] dreg_q;
   reg [1:0] stride_skip_q;
   wire [4:0] op = cmd_q[0][4:0];
   wire is_rw = (op == `FDCH_OP_RDDATA) || (op == `FDCH_OP_WRDATA) || (op == `FDCH_OP_SCANEQ);
   wire is_wr = (op == `FDCH_OP_WRDATA);

   wire ms_tick;
   wire hl_done, hu_done;
   reg hl_load, hu_load;
   fdch_tick #(.DIV(TICK_DIV)) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .tick_q(ms_tick)
   );
   fdch_delay #(.W(8)) u_hload (
      .core_clk(core_clk),
      .rst(rst),
      .tick(ms_tick),
      .load(hl_load),
      .value(hlt_q),
      .done(hl_done)
   );
   fdch_delay #(.W(8)) u_hunload (
      .core_clk(core_clk),
      .rst(rst),
      .tick(ms_tick),
      .load(hu_load),
      .value(hut_q),
      .done(hu_done)
   );

   // Main status register view
   wire busy = (st_q != S_IDLE);
   wire exm = (st_q == S_EXEC) || (st_q == S_HEAD);
   wire [7:0] msr = {rqm_q, dir_q, exm && nodma_q, busy, 4'h0};

   integer i;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE;
         cnt_q <= 4'h0;
         len_q <= 4'h0;
         rcnt_q <= 3'h0;
         rlen_q <= 3'h0;
         for (i = 0; i < 9; i = i + 1)
            cmd_q[i] <= 8'h00;
         for (i = 0; i < 7; i = i + 1)
            res_q[i] <= 8'h00;
         hlt_q <= 8'h01;
         hut_q <= 8'h10;
         step_interval_q <= 4'hf;
         nodma_q <= 1'b0;
         spec_q <= 1'b0;
         tc_seen_q <= 1'b0;
         rdy_int_q <= 1'b0;
         dir_q <= 1'b0;
         rqm_q <= 1'b1;
         rec_q <= 8'h00;
         st0_q <= 8'h00;
         dreg_q <= 8'h00;
         stride_skip_q <= 2'h0;
         db_out <= 8'h00;
         db_oe <= 1'b0;
         int_q <= 1'b0;
         dma_request_output <= 1'b0;
         drive_select_outputs <= 2'h0;
         head_select <= 1'b0;
         head_load <= 1'b0;
         encoding_density_select <= 1'b0;
         cylinder_q <= 8'h00;
         short_sector_length_q <= 8'hff;
         scan_stride_q <= 8'h01;
         host_wr_byte <= 8'h00;
         host_wr_vld <= 1'b0;
         hl_load <= 1'b0;
         hu_load <= 1'b0;
      end else begin
         hl_load <= 1'b0;
         hu_load <= 1'b0;
         host_wr_vld <= 1'b0;
         db_oe <= rd_act;
         if (!(rd_act && db_oe)) db_out <= data_sel ? dreg_q : msr;
         if (head_load && hu_done && st_q == S_IDLE)
            head_load <= 1'b0;
         case (st_q)
            S_IDLE: begin
               dir_q <= 1'b0;
               rqm_q <= 1'b1;
               if (spec_q)
                  drive_select_outputs <= drive_select_outputs + 2'h1;
               if (wr_fall && a2_q) begin
                  cmd_q[0] <= db2_q;
                  cnt_q <= 4'h1;
                  len_q <= cmd_len(db2_q[4:0]);
                  int_q <= 1'b0;
                  st_q <= (cmd_len(db2_q[4:0]) == 4'h1) ? S_EXEC : S_CMD;
               end
               if (spec_q && (rdy3_q != rdy2_q)) begin
                  rdy_int_q <= 1'b1;
                  int_q <= 1'b1;
               end
            end
            S_CMD: begin
               if (wr_fall && a2_q) begin
                  cmd_q[cnt_q] <= db2_q;
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q + 4'h1 == len_q)
                     st_q <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (op == `FDCH_OP_SPECIFY) begin
                  step_interval_q <= cmd_q[1][7:4];
                  hut_q <= {cmd_q[1][3:0], 4'h0};
                  hlt_q <= {cmd_q[2][7:1], 1'b0};
                  nodma_q <= cmd_q[2][0];
                  spec_q <= 1'b1;
                  st_q <= S_IDLE;
               end else if (op == `FDCH_OP_SEEK || op == `FDCH_OP_RECAL) begin
                  drive_select_outputs <= cmd_q[1][1:0];
                  cylinder_q <= (op == `FDCH_OP_RECAL) ? 8'h00 :
                     ((cmd_q[2] > `FDCH_MAX_CYL) ? `FDCH_MAX_CYL : cmd_q[2]);
                  st_q <= S_IDLE;
               end else if (op == `FDCH_OP_SENSEINT) begin
                  res_q[0] <= st0_q | (rdy_int_q ? (8'h01 << `FDCH_ST0_NR) : 8'h00);
                  res_q[1] <= cylinder_q;
                  rdy_int_q <= 1'b0;
                  int_q <= 1'b0;
                  rlen_q <= `FDCH_RES_SENSE;
                  rcnt_q <= 3'h0;
                  dreg_q <= st0_q | (rdy_int_q ? (8'h01 << `FDCH_ST0_NR) : 8'h00);
                  st_q <= S_RES;
               end else if (is_rw) begin
                  drive_select_outputs <= cmd_q[1][1:0];
                  head_select <= cmd_q[1][2];
                  cylinder_q <= cmd_q[2];
                  rec_q <= cmd_q[4];
                  encoding_density_select <= cmd_q[0][`FDCH_BIT_MF];
                  short_sector_length_q <= cmd_q[8];
                  scan_stride_q <= cmd_q[8];
                  stride_skip_q <= 2'h0;
                  tc_seen_q <= 1'b0;
                  rqm_q <= 1'b0;
                  dir_q <= !is_wr;
                  if (!head_load)
                     hl_load <= 1'b1;
                  head_load <= 1'b1;
                  st_q <= S_HEAD;
               end else begin
                  res_q[0] <= `FDCH_ST0_INVALID;
                  dreg_q <= `FDCH_ST0_INVALID;
                  rlen_q <= `FDCH_RES_INV;
                  rcnt_q <= 3'h0;
                  st_q <= S_RES;
               end
            end
            S_HEAD: begin
               if (rd_fall && data_sel) begin
                  int_q <= 1'b0;
                  rqm_q <= 1'b0;
               end
               if (wr_fall && data_sel && is_wr) begin
                  host_wr_byte <= db2_q;
                  host_wr_vld <= 1'b1;
                  int_q <= 1'b0;
                  rqm_q <= 1'b0;
               end
               if (tc && !tc_seen_q)
                  tc_seen_q <= 1'b1;
               if (disk_sector_end && tc_seen_q) begin
                  int_q <= 1'b1;
                  dma_request_output <= 1'b0;
                  rqm_q <= 1'b1;
                  dir_q <= 1'b1;
                  res_q[0] <= {6'h00, head_select, 1'b0} | st0_q;
                  res_q[1] <= 8'h00;
                  res_q[2] <= 8'h00;
                  res_q[3] <= cylinder_q;
                  res_q[4] <= {7'h00, head_select};
                  res_q[5] <= rec_q + 8'h01;
                  res_q[6] <= cmd_q[5];
                  dreg_q <= {6'h00, head_select, 1'b0} | st0_q;
                  rlen_q <= `FDCH_RES_RW;
                  rcnt_q <= 3'h0;
                  hu_load <= 1'b1;
                  st_q <= S_RES;
               end else if (hl_done) begin
                  if (disk_id_vld && disk_id_sector == rec_q)
                     stride_skip_q <= 2'h1;
                  if (disk_sector_end) begin
                     stride_skip_q <= 2'h0;
                     if (rec_q == cmd_q[6] && cmd_q[0][`FDCH_BIT_MT] && !head_select) begin
                        head_select <= 1'b1;
                        rec_q <= 8'h01;
                     end else
                        rec_q <= rec_q + ((scan_stride_q == 8'h02 && op == `FDCH_OP_SCANEQ)
                           ? 8'h02 : 8'h01);
                  end
                  if (stride_skip_q == 2'h1 && !tc_seen_q && !is_wr && disk_byte_vld) begin
                     dreg_q <= disk_byte;
                     rqm_q <= 1'b1;
                     if (nodma_q)
                        int_q <= 1'b1;
                     else
                        dma_request_output <= 1'b1;
                  end
                  if (stride_skip_q == 2'h1 && !tc_seen_q && is_wr && !rqm_q) begin
                     rqm_q <= 1'b1;
                     if (nodma_q)
                        int_q <= 1'b1;
                     else
                        dma_request_output <= 1'b1;
                  end
               end
               if (!dma_acknowledge_input_n)
                  dma_request_output <= 1'b0;
            end
            S_RES: begin
               dir_q <= 1'b1;
               rqm_q <= 1'b1;
               if (rd_fall && a2_q) begin
                  int_q <= 1'b0;
                  rcnt_q <= rcnt_q + 3'h1;
                  dreg_q <= res_q[rcnt_q + 3'h1];
                  if (rcnt_q + 3'h1 == rlen_q)
                     st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // fdch_proto
`default_nettype wire

// ---- verilog/fdch_defines.vh ----
/*
 Constants for the disk controller host protocol block: main status bit
 positions, phase byte counts, opcodes and timing figures.
 Assumes a 100 MHz core clock.
*/
`ifndef FDCH_DEFINES_VH
`define FDCH_DEFINES_VH
// Main status bits
`define FDCH_MSR_RQM 7
`define FDCH_MSR_DIO 6
`define FDCH_MSR_EXM 5
`define FDCH_MSR_BSY 4
// Opcodes (low five bits of first command byte)
`define FDCH_OP_RDDATA 5'h06
`define FDCH_OP_WRDATA 5'h05
`define FDCH_OP_SCANEQ 5'h11
`define FDCH_OP_SPECIFY 5'h03
`define FDCH_OP_SENSEINT 5'h08
`define FDCH_OP_SEEK 5'h0f
`define FDCH_OP_RECAL 5'h07
// Bit positions in first command byte
`define FDCH_BIT_MT 7
`define FDCH_BIT_MF 6
// Byte counts
`define FDCH_LEN_RW 4'h9
`define FDCH_LEN_SPEC 4'h3
`define FDCH_LEN_SEEK 4'h3
`define FDCH_LEN_RECAL 4'h2
`define FDCH_LEN_ONE 4'h1
`define FDCH_RES_RW 3'h7
`define FDCH_RES_SENSE 3'h2
`define FDCH_RES_INV 3'h1
// Status values
`define FDCH_ST0_INVALID 8'h80
`define FDCH_ST0_NR 3
`define FDCH_ST0_ABN 8'h40
// Timing
`define FDCH_CLK_MHZ 100
`define FDCH_MS_NS 1000000
`define FDCH_CLK_NS 10
`define FDCH_TICK_CYC (`FDCH_MS_NS / `FDCH_CLK_NS)
`define FDCH_HLT_STEP_MS 2
`define FDCH_HUT_STEP_MS 16
`define FDCH_SRT_STEP_MS 1
`define FDCH_MAX_CYL 8'h4c
`endif

// ---- verilog/fdch_tick.v ----
/*
 Millisecond tick divider for the host protocol block.
 Assumes a single core clock; tick is a one-cycle enable pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdch_defines.vh"
module fdch_tick #(
   parameter integer DIV = `FDCH_TICK_CYC
) (
   input wire core_clk,
   input wire rst,
   output reg tick_q
);
   reg [19:0] cnt_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 20'h0;
         tick_q <= 1'b0;
      end else if (cnt_q == DIV[19:0] - 20'h1) begin
         cnt_q <= 20'h0;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 20'h1;
         tick_q <= 1'b0;
      end
   end
endmodule // fdch_tick
`default_nettype wire

// ---- verilog/fdch_delay.v ----
/*
 Loadable down counter in units of the millisecond tick.
 Assumes the tick input is a one-cycle enable on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fdch_delay #(
   parameter integer W = 8
) (
   input wire core_clk,
   input wire rst,
   input wire tick,
   input wire load,
   input wire [W-1:0] value,
   output wire done
);
   reg [W-1:0] cnt_q;
   assign done = (cnt_q == {W{1'b0}}) && !load;
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         cnt_q <= {W{1'b0}};
      else if (load)
         cnt_q <= value;
      else if (tick && !done)
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
   end
endmodule // fdch_delay
`default_nettype wire

// ---- verification/fdch_proto_asserts.sv ----
/*
 Concurrent checks on the host side and drive side ports of the disk controller protocol block.
 Assumes one core clock, asynchronous active high reset, bound into fdch_proto.
*/
`timescale 1ns/1ps
`default_nettype none
module fdch_proto_asserts #(
   parameter integer TICK_DIV = 10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic register_select_line,
   input wire logic db_oe,
   input wire logic int_q,
   input wire logic dma_request_output,
   input wire logic dma_acknowledge_input,
   input wire logic transfer_end_input,
   input wire logic disk_sector_end,
   input wire logic [7:0] cylinder_q,
   input wire logic [3:0] step_interval_q,
   input wire logic [7:0] short_sector_length_q,
   input wire logic [7:0] scan_stride_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_oe_needs_read: assert property (
      (rd_n && $past(rd_n) && $past(rd_n, 2) && $past(rd_n, 3)) |-> !db_oe)
      else $error("data bus driven without read strobe");
   a_oe_on_read: assert property (
      ($fell(rd_n) && !cs_n) ##1 !rd_n [*3] |-> db_oe)
      else $error("read strobe did not drive data bus");
   a_ack_clears_req: assert property (
      $fell(dma_acknowledge_input) |-> ##[1:4] !dma_request_output)
      else $error("acknowledge did not clear dma request");
   a_no_int_dma: assert property (
      dma_request_output |-> !int_q)
      else $error("interrupt while dma request pending");
   a_int_clr_read: assert property (
      (int_q && $fell(rd_n) && !cs_n && register_select_line) |-> ##[1:4] !int_q)
      else $error("data read did not clear interrupt");
   a_tc_ends_cmd: assert property (
      (transfer_end_input && $past(transfer_end_input, 3) && disk_sector_end) |-> ##[1:8] int_q)
      else $error("terminal count did not start result phase");
   a_reset_vals: assert property (
      $fell(rst) |-> (step_interval_q == 4'hf && short_sector_length_q == 8'hff
                      && scan_stride_q == 8'h01 && !int_q))
      else $error("wrong values after reset");
   a_cyl_range: assert property (
      cylinder_q <= 8'h4c)
      else $error("cylinder beyond last track");

   c_dma_req: cover property ($rose(dma_request_output));
   c_int: cover property ($rose(int_q));
   c_read: cover property ($rose(db_oe));
endmodule // fdch_proto_asserts

bind fdch_proto fdch_proto_asserts #(.TICK_DIV(TICK_DIV)) fdch_proto_asserts_inst (
   .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
   .register_select_line(register_select_line), .db_oe(db_oe), .int_q(int_q),
   .dma_request_output(dma_request_output), .dma_acknowledge_input(dma_acknowledge_input),
   .transfer_end_input(transfer_end_input), .disk_sector_end(disk_sector_end),
   .cylinder_q(cylinder_q), .step_interval_q(step_interval_q),
   .short_sector_length_q(short_sector_length_q), .scan_stride_q(scan_stride_q));
`default_nettype wire

// ---- verification/fdch_host.sv ----
/*
 Host processor and dma controller model for the disk controller protocol block.
 Assumes strobes are changed just after a core clock edge and held 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fdch_host (
   input wire logic core_clk,
   input wire logic [7:0] db_out,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic register_select_line,
   output logic dma_acknowledge_input,
   output logic transfer_end_input,
   output logic [7:0] db_in
);
   initial begin
      {cs_n, rd_n, wr_n, dma_acknowledge_input} = 4'hf;
      register_select_line = 1'b0;
      transfer_end_input = 1'b0;
      db_in = 8'h00;
   end

   // One bus cycle; execution phase bytes go straight here without polling
   task automatic acc(input logic dma, input logic wr, input logic a, input logic [7:0] wd,
                      output logic [7:0] d);
      @(posedge core_clk);
      cs_n <= dma;
      dma_acknowledge_input <= !dma;
      register_select_line <= a;
      db_in <= wd;
      wr_n <= !wr;
      rd_n <= wr;
      repeat (4) @(posedge core_clk);
      d = db_out;
      {cs_n, dma_acknowledge_input, wr_n, rd_n} <= 4'hf;
      db_in <= ~wd;
      repeat (3) @(posedge core_clk);
   endtask

   // Command or result byte, preceded by status polling
   task automatic xfer(input logic wr, input logic [7:0] wd, output logic [7:0] st,
                       output logic [7:0] d);
      integer i;
      st = 8'h00;
      for (i = 0; i < 200 && st[7:6] !== {1'b1, !wr}; i++) acc(1'b0, 1'b0, 1'b0, 8'h00, st);
      acc(1'b0, wr, 1'b1, wd, d);
   endtask
endmodule // fdch_host
`default_nettype wire

// ---- verification/testbench.sv ----
/*
 Self-checking bench for the disk controller host protocol block.
 Assumes the shortened millisecond divider and a host model on the bus side.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [71:0] RD_CMD = 72'h46_00_00_00_03_01_05_1b_ff;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] disk_byte = 8'h00;
   logic [7:0] disk_id_sector = 8'h00;
   logic disk_byte_vld = 1'b0;
   logic disk_id_vld = 1'b0;
   logic disk_sector_end = 1'b0;
   logic [3:0] drive_ready = 4'hf;
   integer err_total = 0;
   integer n_checks = 0;
   wire cs_n, rd_n, wr_n, register_select_line, dma_acknowledge_input, transfer_end_input;
   wire db_oe, int_q, dma_request_output, head_select, head_load, encoding_density_select;
   wire host_wr_vld;
   wire [7:0] db_in, db_out, cylinder_q, short_sector_length_q, scan_stride_q, host_wr_byte;
   wire [3:0] step_interval_q;
   wire [1:0] drive_select_outputs;

   always #5 core_clk = ~core_clk;

   fdch_proto #(.TICK_DIV(10)) fdch_proto_inst (
      .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .register_select_line(register_select_line), .db_in(db_in), .db_out(db_out),
      .db_oe(db_oe), .int_q(int_q), .dma_request_output(dma_request_output),
      .dma_acknowledge_input(dma_acknowledge_input), .transfer_end_input(transfer_end_input),
      .drive_ready(drive_ready), .drive_select_outputs(drive_select_outputs),
      .head_select(head_select), .head_load(head_load),
      .encoding_density_select(encoding_density_select), .cylinder_q(cylinder_q),
      .step_interval_q(step_interval_q), .short_sector_length_q(short_sector_length_q),
      .scan_stride_q(scan_stride_q), .disk_byte(disk_byte), .disk_byte_vld(disk_byte_vld),
      .disk_id_vld(disk_id_vld), .disk_id_sector(disk_id_sector),
      .disk_sector_end(disk_sector_end), .host_wr_byte(host_wr_byte),
      .host_wr_vld(host_wr_vld));

   fdch_host fdch_host_inst (
      .core_clk(core_clk), .db_out(db_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .register_select_line(register_select_line), .dma_acknowledge_input(dma_acknowledge_input),
      .transfer_end_input(transfer_end_input), .db_in(db_in));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic send(input logic [7:0] d);
      logic [7:0] st;
      logic [7:0] x;
      fdch_host_inst.xfer(1'b1, d, st, x);
      chk(st & 8'hc0, 8'h80);
   endtask

   task automatic take(output logic [7:0] d);
      logic [7:0] st;
      fdch_host_inst.xfer(1'b0, 8'h00, st, d);
      chk(st & 8'hc0, 8'hc0);
   endtask

   task automatic idle_chk;
      logic [7:0] st;
      integer i;
      st = 8'h00;
      for (i = 0; i < 100 && st !== 8'h80; i++) fdch_host_inst.acc(0, 0, 0, 8'h00, st);
      chk(st, 8'h80);
   endtask

   // Drive side strobe: kind 0 data byte, 1 id field, 2 sector end
   task automatic disk(input logic [7:0] b, input logic [1:0] kind);
      @(posedge core_clk);
      disk_byte <= b;
      disk_id_sector <= b;
      disk_byte_vld <= (kind == 2'd0);
      disk_id_vld <= (kind == 2'd1);
      disk_sector_end <= (kind == 2'd2);
      @(posedge core_clk);
      {disk_byte_vld, disk_id_vld, disk_sector_end} <= 3'b000;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic t_reset;
      logic [7:0] v;
      fdch_host_inst.acc(0, 0, 0, 8'h00, v);
      chk(v, 8'h80);
      chk({step_interval_q, 4'h0}, 8'hf0);
      chk(short_sector_length_q, 8'hff);
      chk(scan_stride_q, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_specify(input logic nd);
      logic [3:0] seen;
      integer i;
      send(8'h03);
      send(8'he1);
      send({7'h01, nd});
      idle_chk();
      chk({4'h0, step_interval_q}, 8'h0e);
      seen = 4'h0;
      for (i = 0; i < 8; i++) begin
         @(posedge core_clk);
         seen[drive_select_outputs] = 1'b1;
      end
      chk({4'h0, seen}, 8'h0f);
      $display("test specify done");
   endtask

   task automatic t_invalid;
      logic [7:0] v;
      send(8'h1f);
      take(v);
      chk(v, 8'h80);
      idle_chk();
      $display("test invalid done");
   endtask

   task automatic t_seek;
      logic [7:0] v;
      integer i;
      send(8'h0f);
      send(8'h00);
      send(8'h4c);
      for (i = 0; i < 3000 && cylinder_q !== 8'h4c; i++) @(posedge core_clk);
      chk(cylinder_q, 8'h4c);
      drive_ready <= 4'hd;
      repeat (6) @(posedge core_clk);
      chk({7'h0, int_q}, 8'h01);
      send(8'h08);
      take(v);
      chk(v, 8'h08);
      take(v);
      chk(v, 8'h4c);
      idle_chk();
      $display("test seek done");
   endtask

   task automatic t_read(input logic dma);
      logic [7:0] v;
      integer i;
      integer k;
      t_specify(!dma);
      for (i = 0; i < 9; i++) send(RD_CMD[71 - 8 * i -: 8]);
      chk({7'h0, encoding_density_select}, 8'h01);
      for (i = 0; i < 1000 && head_load !== 1'b1; i++) @(posedge core_clk);
      chk({7'h0, head_load}, 8'h01);
      disk(8'h02, 2'd1);
      disk(8'h5a, 2'd0);
      chk({6'h0, int_q, dma_request_output}, 8'h00);
      repeat (30) @(posedge core_clk);
      disk(8'h03, 2'd1);
      for (k = 0; k < 2; k++) begin
         disk(8'ha0 + k[7:0], 2'd0);
         for (i = 0; i < 20 && (dma ? dma_request_output : int_q) !== 1'b1; i++)
            @(posedge core_clk);
         chk({6'h0, int_q, dma_request_output}, {6'h0, !dma, dma});
         fdch_host_inst.acc(dma, 1'b0, 1'b1, 8'h00, v);
         chk(v, 8'ha0 + k[7:0]);
         chk({6'h0, int_q, dma_request_output}, 8'h00);
      end
      @(posedge core_clk) fdch_host_inst.transfer_end_input <= 1'b1;
      repeat (4) @(posedge core_clk);
      disk(8'h00, 2'd2);
      for (i = 0; i < 50 && int_q !== 1'b1; i++) @(posedge core_clk);
      chk({7'h0, int_q}, 8'h01);
      fdch_host_inst.transfer_end_input <= 1'b0;
      take(v);
      chk({7'h0, int_q}, 8'h00);
      for (k = 1; k < 7; k++) begin
         take(v);
         if (k == 5) chk(v, 8'h04);
      end
      idle_chk();
      $display("test read done");
   endtask

   task automatic t_write;
      logic [7:0] v;
      integer i;
      send(8'h45);
      for (i = 1; i < 9; i++) send(RD_CMD[71 - 8 * i -: 8]);
      repeat (30) @(posedge core_clk);
      disk(8'h03, 2'd1);
      for (i = 0; i < 20 && int_q !== 1'b1; i++) @(posedge core_clk);
      chk({7'h0, int_q}, 8'h01);
      fdch_host_inst.acc(1'b0, 1'b1, 1'b1, 8'h3c, v);
      chk(host_wr_byte, 8'h3c);
      @(posedge core_clk) fdch_host_inst.transfer_end_input <= 1'b1;
      repeat (4) @(posedge core_clk);
      disk(8'h00, 2'd2);
      fdch_host_inst.transfer_end_input <= 1'b0;
      for (i = 0; i < 7; i++) take(v);
      idle_chk();
      $display("test write done");
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_specify(1'b1);
      t_invalid();
      t_seek();
      t_read(1'b0);
      t_write();
      t_read(1'b1);
      close_out();
   end

   initial begin
      #900000;
      err_total = err_total + 1;
      close_out();
   end
endmodule // testbench
`default_nettype wire
